// ---- rtl/scm_pkg.sv ----
// Purpose: constants shared by the system clock mode configuration block
// Assumes: one core clock, registers reached over Avalon-MM at word index times four
// Notes:   one-hot operating mode enum and warm-up exponent decode live here
//
// How it works
// - source bit picks fast (0) or slow (1); gear 000..100 divides by 1..16
// - halt field 01 stop, 10 idle one, 11 idle two; resets to 11
// - in stop, pin-hold 0 turns pin drivers off, 1 keeps them
// - unimplemented register bits read back with no meaning; here zero
// - clock output select 0 drives slow clock, 1 drives core clock outside stop and low in stop
// - warm-up timer counts the periods chosen by the length field
// - gear divider acts only while the fast source is selected
package scm_pkg;
  // =====================================================================
  // register indices (byte address is four times the index)
  localparam int         ADDR_W       = 10;
  localparam logic [7:0] IDX_SRC_GEAR = 8'hE1;
  localparam logic [7:0] IDX_OUT_CFG  = 8'hE2;
  localparam logic [7:0] IDX_WUP_CTRL = 8'hE3;
  // =====================================================================
  // field positions
  localparam int SRC_SEL_BIT = 3;
  localparam int GEAR_LSB    = 0;
  localparam int OUT_SEL_BIT = 6;
  localparam int WUP_LSB     = 4;
  localparam int HALT_LSB    = 2;
  localparam int HOLD_BIT    = 0;
  localparam int WUP_GO_BIT  = 0;
  // =====================================================================
  // reset values
  localparam logic       SRC_RST     = 1'h0;
  localparam logic [2:0] GEAR_RST    = 3'h0;
  localparam logic       OUT_SEL_RST = 1'h0;
  localparam logic [1:0] WUP_RST     = 2'h2;
  localparam logic [1:0] HALT_RST    = 2'h3;
  localparam logic       HOLD_RST    = 1'h0;
  // =====================================================================
  // halt codes and gear limit
  localparam logic [1:0] HALT_STOP  = 2'h1;
  localparam logic [1:0] HALT_IDLE_MODE_ONE = 2'h2;
  localparam logic [1:0] HALT_IDLE_MODE_TWO = 2'h3;
  localparam logic [2:0] GEAR_MAX   = 3'h4;
  localparam int         SYNC_DEPTH = 3;
  localparam int         WUP_CNT_W  = 18;

  typedef enum logic [3:0] {
    MODE_RUN   = 4'h1,
    MODE_STOP  = 4'h2,
    MODE_IDLE_MODE_ONE = 4'h4,
    MODE_IDLE_MODE_TWO = 4'h8
  } scm_mode_t;

  // warm-up exponent per length code
  function automatic logic [4:0] scm_wup_exp(input logic [1:0] code);
    case (code)
      2'h0:    scm_wup_exp = 5'h12;
      2'h1:    scm_wup_exp = 5'h08;
      2'h2:    scm_wup_exp = 5'h0E;
      default: scm_wup_exp = 5'h10;
    endcase
  endfunction
endpackage

// ---- rtl/scm_gear_div.sv ----
// Purpose: divides fast oscillator ticks by 1, 2, 4, 8 or 16
// Assumes: fast_tick is a one-cycle pulse per fast oscillator period
// Notes:   reserved codes run at the slowest gear
module scm_gear_div (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // control
  input  wire logic       fast_tick,
  input  wire logic [2:0] gear,
  // result
  output logic            gear_tick
);
  import scm_pkg::*;

  logic [3:0] cnt;
  logic [3:0] next_cnt;
  logic       next_tick;
  logic [2:0] gear_eff;
  logic [3:0] term;

  // reserved codes clamp to /16 so the core never runs faster than asked
  always_comb begin
    gear_eff  = (gear > GEAR_MAX) ? GEAR_MAX : gear;
    term      = 4'((5'h01 << gear_eff) - 5'h01);
    next_cnt  = cnt;
    next_tick = 1'b0;
    if (fast_tick) begin
      if (cnt >= term) begin
        next_cnt  = 4'h0;
        next_tick = 1'b1;
      end else begin
        next_cnt = cnt + 4'h1;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt       <= 4'h0;
      gear_tick <= 1'b0;
    end else begin
      cnt       <= next_cnt;
      gear_tick <= next_tick;
    end
  end
endmodule

// ---- rtl/scm_warmup.sv ----
// Purpose: warm-up timer counting oscillator periods before a clock switch
// Assumes: osc_tick pulses once per period of the oscillator being started
// Notes:   a start while busy restarts the count
module scm_warmup (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // control
  input  wire logic       start,
  input  wire logic       osc_tick,
  input  wire logic [1:0] length_sel,
  // status
  output logic            busy
);
  import scm_pkg::*;

  logic [WUP_CNT_W-1:0] cnt;
  logic [WUP_CNT_W-1:0] next_cnt;
  logic [WUP_CNT_W-1:0] last;
  logic                 next_busy;

  // length sampled live; changing it mid-count shortens or stretches the wait
  always_comb begin
    last      = WUP_CNT_W'((19'h0_0001 << scm_wup_exp(length_sel)) - 19'h0_0001);
    next_cnt  = cnt;
    next_busy = busy;
    if (start) begin
      next_cnt  = '0;
      next_busy = 1'b1;
    end else if (busy && osc_tick) begin
      if (cnt == last) begin
        next_busy = 1'b0;
      end else begin
        next_cnt = cnt + WUP_CNT_W'(1);
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt  <= '0;
      busy <= 1'b0;
    end else begin
      cnt  <= next_cnt;
      busy <= next_busy;
    end
  end
endmodule

// ---- rtl/scm_top.sv ----
// Purpose: clock source, gear, clock output, warm-up length and halt mode registers
// Assumes: oscillator levels arrive on pins; halt and wake pulses come from core logic
// Notes:   Avalon-MM slave answers every access after one wait cycle
module scm_top (
  // clock and reset
  input  wire logic                      CLK,
  input  wire logic                      RESET_N,
  // avalon-mm slave
  input  wire logic [scm_pkg::ADDR_W-1:0] ADDRESS,
  input  wire logic                      READ,
  input  wire logic                      WRITE,
  input  wire logic [31:0]               WRITEDATA,
  input  wire logic [3:0]                BYTEENABLE,
  output logic      [31:0]               READDATA,
  output logic                           WAITREQUEST,
  // oscillator pins
  input  wire logic                      FAST_OSC_IN,
  input  wire logic                      SLOW_OSC_IN,
  // core events
  input  wire logic                      HALT_EXEC,
  input  wire logic                      WAKE_EVENT,
  // clock and mode outputs
  output logic                           CORE_CLOCK,
  output logic                           CLOCK_OUTPUT_PIN,
  output logic                           STOP_ACTIVE,
  output logic                           IDLE_MODE_ONE_ACTIVE,
  output logic                           IDLE_MODE_TWO_ACTIVE,
  output logic                           PIN_DRIVE_OFF,
  output logic                           WARMUP_BUSY
);
  import scm_pkg::*;

  // =====================================================================
  // reset release
  logic rst_meta;
  logic rst_n;

  // async assert, two-stage release so the whole block leaves reset together
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  // =====================================================================
  // oscillator pin synchronisers
  logic [1:0] s1;
  logic [1:0] s2;
  logic [1:0] s3;
  logic [1:0] filt;
  logic [1:0] next_filt;
  logic [1:0] tick;
  logic       fast_tick;
  logic       slow_tick;
  logic       slow_level;

  // a level counts only once stages two and three agree; ticks on rising edges
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      next_filt[i] = (s2[i] == s3[i]) ? s3[i] : filt[i];
      tick[i]      = next_filt[i] & ~filt[i];
    end
  end

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      s1   <= 2'h0;
      s2   <= 2'h0;
      s3   <= 2'h0;
      filt <= 2'h0;
    end else begin
      s1   <= {SLOW_OSC_IN, FAST_OSC_IN};
      s2   <= s1;
      s3   <= s2;
      filt <= next_filt;
    end
  end

  assign fast_tick  = tick[0];
  assign slow_tick  = tick[1];
  assign slow_level = filt[1];
  // =====================================================================
  // avalon-mm handshake
  logic [7:0]  idx;
  logic        req;
  logic        accept;
  logic        next_wait;
  logic [31:0] next_rdata;
  logic        wr_src;
  logic        wr_cfg;
  logic        wr_wup;

  // configuration state
  logic       src_sel;
  logic [2:0] gear;
  logic       out_sel;
  logic [1:0] wup_len;
  logic [1:0] halt_code;
  logic       pin_hold;
  logic       next_src_sel;
  logic [2:0] next_gear;
  logic       next_out_sel;
  logic [1:0] next_wup_len;
  logic [1:0] next_halt_code;
  logic       next_pin_hold;
  logic       wup_start;
  logic       wup_busy;

  assign idx    = ADDRESS[9:2];
  assign req    = READ | WRITE;
  // a request completes at the edge that sees waitrequest low
  assign accept = req & ~WAITREQUEST;
  assign wr_src = accept & WRITE & BYTEENABLE[0] & (idx == IDX_SRC_GEAR);
  assign wr_cfg = accept & WRITE & BYTEENABLE[0] & (idx == IDX_OUT_CFG);
  assign wr_wup = accept & WRITE & BYTEENABLE[0] & (idx == IDX_WUP_CTRL);

  // one wait cycle per access; unmapped reads give zero, writes are dropped
  always_comb begin
    next_wait  = ~(req & WAITREQUEST);
    next_rdata = READDATA;
    if (req && WAITREQUEST) begin
      next_rdata = 32'h0000_0000;
      case (idx)
        IDX_SRC_GEAR: begin
          next_rdata[SRC_SEL_BIT]          = src_sel;
          next_rdata[GEAR_LSB+2:GEAR_LSB]  = gear;
        end
        IDX_OUT_CFG: begin
          next_rdata[OUT_SEL_BIT]          = out_sel;
          next_rdata[WUP_LSB+1:WUP_LSB]    = wup_len;
          next_rdata[HALT_LSB+1:HALT_LSB]  = halt_code;
          next_rdata[HOLD_BIT]             = pin_hold;
        end
        IDX_WUP_CTRL: next_rdata[WUP_GO_BIT] = wup_busy;
        default:      next_rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      WAITREQUEST <= 1'b1;
      READDATA    <= 32'h0000_0000;
    end else begin
      WAITREQUEST <= next_wait;
      READDATA    <= next_rdata;
    end
  end

  // =====================================================================
  // configuration registers
  always_comb begin
    next_src_sel   = src_sel;
    next_gear      = gear;
    next_out_sel   = out_sel;
    next_wup_len   = wup_len;
    next_halt_code = halt_code;
    next_pin_hold  = pin_hold;
    if (wr_src) begin
      next_src_sel = WRITEDATA[SRC_SEL_BIT];
      next_gear    = WRITEDATA[GEAR_LSB+2:GEAR_LSB];
    end
    if (wr_cfg) begin
      next_out_sel   = WRITEDATA[OUT_SEL_BIT];
      next_wup_len   = WRITEDATA[WUP_LSB+1:WUP_LSB];
      next_halt_code = WRITEDATA[HALT_LSB+1:HALT_LSB];
      next_pin_hold  = WRITEDATA[HOLD_BIT];
    end
  end

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      src_sel   <= SRC_RST;
      gear      <= GEAR_RST;
      out_sel   <= OUT_SEL_RST;
      wup_len   <= WUP_RST;
      halt_code <= HALT_RST;
      pin_hold  <= HOLD_RST;
    end else begin
      src_sel   <= next_src_sel;
      gear      <= next_gear;
      out_sel   <= next_out_sel;
      wup_len   <= next_wup_len;
      halt_code <= next_halt_code;
      pin_hold  <= next_pin_hold;
    end
  end

  // =====================================================================
  // warm-up timer on the oscillator about to be switched to
  logic wup_tick;

  assign wup_start = wr_wup & WRITEDATA[WUP_GO_BIT];
  assign wup_tick  = src_sel ? fast_tick : slow_tick;

  scm_warmup u_warmup (
    .clk        (CLK),
    .rst_n      (rst_n),
    .start      (wup_start),
    .osc_tick   (wup_tick),
    .length_sel (wup_len),
    .busy       (wup_busy)
  );

  assign WARMUP_BUSY = wup_busy;
  // =====================================================================
  // operating mode
  scm_mode_t mode;
  scm_mode_t next_mode;

  // register writes alone never move the mode; only halt and wake do
  always_comb begin
    next_mode = mode;
    case (mode)
      MODE_RUN: begin
        if (HALT_EXEC) begin
          case (halt_code)
            HALT_STOP:  next_mode = MODE_STOP;
            HALT_IDLE_MODE_ONE: next_mode = MODE_IDLE_MODE_ONE;
            HALT_IDLE_MODE_TWO: next_mode = MODE_IDLE_MODE_TWO;
            default:    next_mode = MODE_RUN;
          endcase
        end
      end
      MODE_STOP, MODE_IDLE_MODE_ONE, MODE_IDLE_MODE_TWO: begin
        if (WAKE_EVENT) next_mode = MODE_RUN;
      end
      default: next_mode = MODE_RUN;
    endcase
  end

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      mode <= MODE_RUN;
    end else begin
      mode <= next_mode;
    end
  end

  assign STOP_ACTIVE  = mode[1];
  assign IDLE_MODE_ONE_ACTIVE = mode[2];
  assign IDLE_MODE_TWO_ACTIVE = mode[3];
  // =====================================================================
  // core clock, clock output pin and pin drivers
  logic gear_tick;
  logic core_tick;
  logic next_core;
  logic next_clk_out;
  logic next_drive_off;

  scm_gear_div u_gear (
    .clk       (CLK),
    .rst_n     (rst_n),
    .fast_tick (fast_tick),
    .gear      (gear),
    .gear_tick (gear_tick)
  );

  // core level toggles per tick, so it runs at half the tick rate
  always_comb begin
    core_tick      = src_sel ? slow_tick : gear_tick;
    next_core      = (core_tick && !STOP_ACTIVE) ? ~CORE_CLOCK : CORE_CLOCK;
    next_clk_out   = out_sel ? (next_core & ~STOP_ACTIVE) : slow_level;
    next_drive_off = (next_mode == MODE_STOP) && !next_pin_hold;
  end

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      CORE_CLOCK       <= 1'b0;
      CLOCK_OUTPUT_PIN <= 1'b0;
      PIN_DRIVE_OFF    <= 1'b0;
    end else begin
      CORE_CLOCK       <= next_core;
      CLOCK_OUTPUT_PIN <= next_clk_out;
      PIN_DRIVE_OFF    <= next_drive_off;
    end
  end

  // =====================================================================
  // assertions
  property p_gear_write;
    @(posedge CLK) disable iff (!rst_n)
      wr_src |=> (gear == $past(WRITEDATA[2:0])) && (src_sel == $past(WRITEDATA[3]));
  endproperty
  a_gear_write: assert property (p_gear_write) else $error("gear or source not stored");
  property p_wup_len_write;
    @(posedge CLK) disable iff (!rst_n)
      wr_cfg |=> wup_len == $past(WRITEDATA[5:4]);
  endproperty
  a_wup_len_write: assert property (p_wup_len_write) else $error("warm-up length not stored");
  property p_halt_stop;
    @(posedge CLK) disable iff (!rst_n)
      (HALT_EXEC && mode == MODE_RUN && halt_code == HALT_STOP) |=> STOP_ACTIVE;
  endproperty
  a_halt_stop: assert property (p_halt_stop) else $error("halt did not enter stop");
  property p_pin_off;
    @(posedge CLK) disable iff (!rst_n)
      PIN_DRIVE_OFF |-> (STOP_ACTIVE && !pin_hold);
  endproperty
  a_pin_off: assert property (p_pin_off) else $error("pin drivers off outside stop");
  property p_reserved_zero;
    @(posedge CLK) disable iff (!rst_n)
      (READ && !WAITREQUEST && idx == IDX_SRC_GEAR) |-> READDATA[31:4] == 28'h000_0000;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("unused bits not zero");
  property p_clk_out_slow;
    @(posedge CLK) disable iff (!rst_n)
      (!out_sel && $past(!out_sel)) |-> CLOCK_OUTPUT_PIN == $past(slow_level);
  endproperty
  a_clk_out_slow: assert property (p_clk_out_slow) else $error("clock pin not slow clock");
  property p_wup_start;
    @(posedge CLK) disable iff (!rst_n)
      wup_start |=> WARMUP_BUSY [*2];
  endproperty
  a_wup_start: assert property (p_wup_start) else $error("warm-up did not start");
  property p_slow_core;
    @(posedge CLK) disable iff (!rst_n)
      ($past(src_sel) && $changed(CORE_CLOCK)) |-> $past(slow_tick);
  endproperty
  a_slow_core: assert property (p_slow_core) else $error("core clock not from slow source");
  property p_mode_hold;
    @(posedge CLK) disable iff (!rst_n)
      (!HALT_EXEC && !WAKE_EVENT) |=> $stable(mode);
  endproperty
  a_mode_hold: assert property (p_mode_hold) else $error("mode moved without halt");
  c_stop:  cover property (@(posedge CLK) disable iff (!rst_n) STOP_ACTIVE ##1 !STOP_ACTIVE);
  c_idle_mode_one: cover property (@(posedge CLK) disable iff (!rst_n) $rose(IDLE_MODE_ONE_ACTIVE));
  c_wup:   cover property (@(posedge CLK) disable iff (!rst_n) $fell(WARMUP_BUSY));
  c_read:  cover property (@(posedge CLK) disable iff (!rst_n) READ && !WAITREQUEST);
endmodule

// ---- tb/tb_top.sv ----
// Purpose: self-checking bench for the clock mode configuration block
// Assumes: one wait cycle per bus access; both oscillators are made by the bench
// Notes:   seeded random register traffic with hand-picked corner cases
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import scm_pkg::*;
  // ==========================================================
  // signals
  logic                CLK         = 1'b0;
  logic                RESET_N     = 1'b0;
  logic [ADDR_W-1:0]   ADDRESS     = '0;
  logic                READ        = 1'b0;
  logic                WRITE       = 1'b0;
  logic [31:0]         WRITEDATA   = '0;
  logic [3:0]          BYTEENABLE  = '0;
  logic                FAST_OSC_IN = 1'b0;
  logic                SLOW_OSC_IN = 1'b0;
  logic                HALT_EXEC   = 1'b0;
  logic                WAKE_EVENT  = 1'b0;
  logic [31:0]         READDATA;
  logic                WAITREQUEST;
  logic                CORE_CLOCK;
  logic                CLOCK_OUTPUT_PIN;
  logic                STOP_ACTIVE;
  logic                IDLE_MODE_ONE_ACTIVE;
  logic                IDLE_MODE_TWO_ACTIVE;
  logic                PIN_DRIVE_OFF;
  logic                WARMUP_BUSY;
  int                  n_fail      = 0;
  int                  n_tests     = 0;
  int                  osc_cnt     = 0;
  int                  seed_init;
  logic [7:0]          m_src, m_cfg;
  // ==========================================================
  // clock and oscillators: fast period 4 cycles, slow period 16
  always #4 CLK = ~CLK;
  always @(posedge CLK) begin
    osc_cnt <= osc_cnt + 1;
    if (osc_cnt % 2 == 1) FAST_OSC_IN <= ~FAST_OSC_IN;
    if (osc_cnt % 8 == 7) SLOW_OSC_IN <= ~SLOW_OSC_IN;
  end
  scm_top i_scm_top (
    .CLK(CLK), .RESET_N(RESET_N), .ADDRESS(ADDRESS), .READ(READ), .WRITE(WRITE),
    .WRITEDATA(WRITEDATA), .BYTEENABLE(BYTEENABLE), .READDATA(READDATA),
    .WAITREQUEST(WAITREQUEST), .FAST_OSC_IN(FAST_OSC_IN), .SLOW_OSC_IN(SLOW_OSC_IN),
    .HALT_EXEC(HALT_EXEC), .WAKE_EVENT(WAKE_EVENT), .CORE_CLOCK(CORE_CLOCK),
    .CLOCK_OUTPUT_PIN(CLOCK_OUTPUT_PIN), .STOP_ACTIVE(STOP_ACTIVE),
    .IDLE_MODE_ONE_ACTIVE(IDLE_MODE_ONE_ACTIVE), .IDLE_MODE_TWO_ACTIVE(IDLE_MODE_TWO_ACTIVE),
    .PIN_DRIVE_OFF(PIN_DRIVE_OFF), .WARMUP_BUSY(WARMUP_BUSY)
  );
  // ==========================================================
  // reporting
  task automatic summarize();
    $display("comparisons=%0d mismatches=%0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // ==========================================================
  // avalon master: hold the request until waitrequest is seen low
  task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] d,
                     input logic [3:0] be, output logic [31:0] q);
    int i;
    @(posedge CLK);
    ADDRESS    <= {idx, 2'b00};
    READ       <= ~wr;
    WRITE      <= wr;
    WRITEDATA  <= ($urandom & 32'hFFFF_FF00) | {24'h00_0000, d}; // upper bits must be ignored
    BYTEENABLE <= be;
    for (i = 0; i < 20; i++) begin
      @(posedge CLK);
      if (WAITREQUEST === 1'b0) break;
    end
    if (i == 20) begin
      chk(32'h0000_0000, 32'h0000_0001);
      summarize();
    end
    q = READDATA;
    READ  <= 1'b0;
    WRITE <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic [31:0] q;
    bus(1'b1, idx, d, 4'hF, q);
  endtask
  task automatic rd_chk(input logic [7:0] idx, input logic [7:0] exp);
    logic [31:0] q;
    bus(1'b0, idx, 8'h00, 4'hF, q);
    chk(q, {24'h00_0000, exp});
  endtask
  // one-cycle core event, mode outputs settle at the edge that sees it
  task automatic pulse(input logic halt);
    @(posedge CLK);
    if (halt) HALT_EXEC <= 1'b1;
    else WAKE_EVENT <= 1'b1;
    @(posedge CLK);
    HALT_EXEC  <= 1'b0;
    WAKE_EVENT <= 1'b0;
    #1;
  endtask
  // half period of core clock (sel 0) or clock output pin (sel 1); early intervals dropped
  task automatic half(input logic sel, output int n);
    logic v;
    int k;
    for (k = 0; k < 4; k++) begin
      v = sel ? CLOCK_OUTPUT_PIN : CORE_CLOCK;
      n = 0;
      do begin
        @(posedge CLK);
        n++;
      end while ((sel ? CLOCK_OUTPUT_PIN : CORE_CLOCK) === v && n < 400);
    end
    if (n >= 400) begin
      chk(32'h0000_0000, 32'h0000_0001);
      summarize();
    end
  endtask
  function automatic int exp_half(input logic src, input logic [2:0] g);
    if (src) return 16;
    return 4 << ((g > 3'h4) ? 4 : int'(g));
  endfunction
  task automatic do_reset();
    @(posedge CLK);
    RESET_N <= 1'b0;
    repeat (5) @(posedge CLK);
    #1;
    chk(WAITREQUEST, 1'b1);
    chk(READDATA, 32'h0000_0000);
    @(posedge CLK);
    RESET_N <= 1'b1;
    repeat (3) @(posedge CLK);
    rd_chk(IDX_SRC_GEAR, 8'h00);
    rd_chk(IDX_OUT_CFG, 8'h2C);
    m_src = 8'h00;
    m_cfg = 8'h2C;
  endtask
  // ==========================================================
  // main sequence
  initial begin
    logic [7:0]  d, idx;
    logic [3:0]  be;
    logic [31:0] q;
    logic        c;
    int          n, p;
    seed_init = $urandom(5);
    do_reset();
    // random traffic, unmapped places and disabled lanes among it
    repeat (24) begin
      d  = 8'($urandom);
      be = 4'($urandom_range(0, 15));
      // each write goes to the source and gear register, the output config register or the unmapped index 8'h10
      case ($urandom_range(0, 2))
        0: idx = IDX_SRC_GEAR;
        1: idx = IDX_OUT_CFG;
        default: idx = 8'h10 + 8'($urandom_range(0, 0));
      endcase
      if (idx == IDX_OUT_CFG) d[3:2] = 2'h1 + 2'($urandom_range(0, 2));
      bus(1'b1, idx, d, be, q);
      if (be[0] && idx == IDX_SRC_GEAR) m_src = d & 8'h0F;
      if (be[0] && idx == IDX_OUT_CFG) m_cfg = d & 8'h7D;
      rd_chk(IDX_SRC_GEAR, m_src);
      rd_chk(IDX_OUT_CFG, m_cfg);
      rd_chk(8'h10, 8'h00);
    end
    // every gear code with both sources; clock output select alternates
    for (int k = 0; k < 16; k++) begin
      d = {4'($urandom), k[3], k[2:0]};
      wr(IDX_SRC_GEAR, d);
      wr(IDX_OUT_CFG, {1'b0, k[0], 6'h2C});
      rd_chk(IDX_SRC_GEAR, d & 8'h0F);
      half(1'b0, n);
      chk(n, exp_half(k[3], k[2:0]));
      half(1'b1, n);
      chk(n, k[0] ? exp_half(k[3], k[2:0]) : 8);
    end
    // halt codes with both pin-hold settings
    wr(IDX_SRC_GEAR, 8'h00);
    for (int k = 0; k < 8; k++) begin
      d = {2'b01, 2'b01, k[2:1], 1'b0, k[0]};
      wr(IDX_OUT_CFG, d);
      rd_chk(IDX_OUT_CFG, d);
      repeat (5) @(posedge CLK);
      chk({STOP_ACTIVE, IDLE_MODE_ONE_ACTIVE, IDLE_MODE_TWO_ACTIVE, PIN_DRIVE_OFF}, 4'h0);
      pulse(1'b1);
      chk({STOP_ACTIVE, IDLE_MODE_ONE_ACTIVE, IDLE_MODE_TWO_ACTIVE, PIN_DRIVE_OFF},
          {k[2:1] == 2'h1, k[2:1] == 2'h2, k[2:1] == 2'h3, k[2:1] == 2'h1 && !k[0]});
      if (k[2:1] == HALT_STOP) begin
        c = CORE_CLOCK;
        repeat (40) @(posedge CLK);
        chk(CORE_CLOCK, c);
        chk(CLOCK_OUTPUT_PIN, 1'b0);
        pulse(1'b1);
        chk(STOP_ACTIVE, 1'b1);
      end
      pulse(1'b0);
      chk({STOP_ACTIVE, IDLE_MODE_ONE_ACTIVE, IDLE_MODE_TWO_ACTIVE, PIN_DRIVE_OFF}, 4'h0);
    end
    // warm-up of 2^8 periods of the oscillator not in use
    for (int s = 0; s < 2; s++) begin
      wr(IDX_SRC_GEAR, {4'h0, s[0], 3'h0});
      wr(IDX_OUT_CFG, 8'h1C);
      wr(IDX_WUP_CTRL, 8'h01);
      #1;
      chk(WARMUP_BUSY, 1'b1);
      rd_chk(IDX_WUP_CTRL, 8'h01);
      p = s ? 4 : 16;
      n = 6;
      while (WARMUP_BUSY === 1'b1 && n < 6000) begin
        @(posedge CLK);
        n++;
      end
      chk(n >= 255 * p - 12 && n <= 257 * p + 12, 1'b1);
      // a used-up bound has already failed the range check above
      if (n >= 6000) summarize();
    end
    // second reset in mid-run brings defaults back
    wr(IDX_SRC_GEAR, 8'h0C);
    do_reset();
    summarize();
  end
endmodule
